// ===== tb_thermal_model_overcurrent_fuse.sv
// Bench: integer heating model checked after every sample and read.
// Assumes tmof_front feeds samples; one slave drives hready.
`timescale 1ns/1ps
`include "tmof_consts.svh"
module tb_thermal_model_overcurrent_fuse;
  logic        clk_i = 1'b0;                        // Bench clock
  logic        rst_b_i = 1'b0;                      // Reset, low active
  logic [31:0] haddr = '0, hwdata = '0, rd_s, hrdata, seed = 32'h15;
  logic [1:0]  htrans = 2'h0;                        // Idle at start
  logic        hwrite = 1'b0, go = 1'b0, rdy_s, hready, hresp, hresp_s, fopen, irq, vld;
  logic [15:0] cur = '0, scur;                       // Sample values
  logic [2:0]  rng = 3'h0;                           // Range select
  logic [5:0]  req, shen;                            // Shunt lines
  logic [3:0]  eng = '0, stat = '0, msk = '0;        // Model flags
  logic [31:0] thr [4] = '{default: 32'hffffffff};   // Model thresholds
  logic [31:0] kk [4] = '{default: 32'h0};           // Model decay
  logic [31:0] rthr [6] = '{default: 32'hffffffff};  // Per-range threshold
  logic [31:0] rk [6] = '{default: 32'h0};           // Per-range decay
  longint      acc [4] = '{default: 0};              // Model accumulators
  int          err_count = 0, total_checks = 0;
  always #10 clk_i = ~clk_i;
  // Mid-cycle copies equal what the next rising edge samples
  always @(negedge clk_i) begin
    rdy_s = hready;
    rd_s  = hrdata;
    hresp_s = hresp;
  end
  tmof_front front (.clk_i(clk_i), .go_i(go), .cur_i(cur), .range_i(rng), .valid_o(vld), .cur_o(scur), .req_o(req));
  tmof_fuse uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .smp_valid_i(vld), .smp_cur_i(scur), .range_i(rng),
    .shunt_req_i(req), .shunt_en_o(shen), .fuse_open_o(fopen), .irq_o(irq));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Single word transfer; waits on hready in both phases
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= `TMOF_HTRANS_NONSEQ;
    do @(posedge clk_i); while (rdy_s !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_i); while (rdy_s !== 1'b1);
    q = rd_s;
    chk("hresp", 32'h0, {31'h0, hresp_s});
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk("read", e, q);
  endtask : rdc
  // Outputs after the fuse walk lag: engaged, shunts, interrupt
  task automatic outs();
    repeat (5) @(posedge clk_i);
    chk("fuse_open", {31'h0, |eng}, {31'h0, fopen});
    chk("shunt_en", |eng ? 32'h0 : 32'h1 << rng, {26'h0, shen});
    chk("irq", {31'h0, |(stat & msk)}, {31'h0, irq});
  endtask : outs
  task automatic sample(input logic [15:0] c);
    longint n;
    go  <= 1'b1;
    cur <= c;
    @(posedge clk_i);
    go  <= 1'b0;
    for (int ch = 0; ch < 4; ch++) begin
      n = acc[ch] + longint'($signed(c)) * $signed(c)
          + ((acc[ch] * longint'($signed(ch == 2 ? rk[rng] : kk[ch]))) >>> 16);
      acc[ch] = (n < 0) ? 0 : (n > 64'hffffffff) ? 64'hffffffff : n;
      if (!eng[ch] && acc[ch] > (ch == 2 ? rthr[rng] : thr[ch])) begin
        eng[ch]  = 1'b1;
        stat[ch] = 1'b1;
      end
    end
    outs();
  endtask : sample
  task automatic clr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] m);
    wr(a, d);
    for (int ch = 0; ch < 4; ch++) if (m[ch]) begin
      eng[ch] = 1'b0;
      acc[ch] = 0;
    end
    outs();
  endtask : clr
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  initial begin
    #400000;
    err_count++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    rdc(`TMOF_A_MASK, 32'h0);
    rdc(`TMOF_A_U0_THR, 32'hffffffff);
    rdc(`TMOF_A_RK0, 32'h0);
    rdc(8'hfc, 32'h0);
    kk[1] = 32'hffff8000;
    wr(`TMOF_A_U1_K, kk[1]);
    for (int r = 0; r < 12; r++) begin
      rng <= 3'(r % 6);
      for (int ch = 0; ch < 4; ch++) begin
        seed = xs(seed);
        if (ch == 2) rthr[r % 6] = 32'd4000 + seed[15:0];
        else thr[ch] = 32'd10000 + seed[15:0];
      end
      rk[r % 6] = {16'hffff, seed[31:16]};
      msk = seed[19:16];
      wr(`TMOF_A_U0_THR, thr[0]);
      wr(`TMOF_A_U1_THR, thr[1]);
      wr(`TMOF_A_MAX_THR, thr[3]);
      wr(8'(`TMOF_A_RTHR0 + 4 * (r % 6)), rthr[r % 6]);
      wr(8'(`TMOF_A_RK0 + 4 * (r % 6)), rk[r % 6]);
      wr(`TMOF_A_MASK, {28'h0, msk});
      for (int s = 0; s < 40 && eng == 4'h0; s++) begin
        seed = xs(seed);
        sample({{8{seed[7]}}, seed[7:0]});
      end
      rdc(`TMOF_A_ENGAGED, {28'h0, eng});
      rdc(`TMOF_A_STAT, {28'h0, stat});
      if (r < 6) clr(`TMOF_A_CLEAR, {28'h0, eng & (~eng + 4'h1)}, eng & (~eng + 4'h1));
      rdc(`TMOF_A_ENGAGED, {28'h0, eng});
      wr(`TMOF_A_STAT, 32'hf);
      stat = 4'h0;
      clr(`TMOF_A_CTRL, 32'h1, 4'hf);
    end
    // User channel one sized for a minimum trip current of 40 with half decay
    thr[0] = 32'hffffffff;
    thr[1] = 32'd3200;
    thr[3] = 32'hffffffff;
    rthr[rng] = 32'hffffffff;
    wr(`TMOF_A_U0_THR, thr[0]);
    wr(`TMOF_A_U1_THR, thr[1]);
    wr(`TMOF_A_MAX_THR, thr[3]);
    wr(8'(`TMOF_A_RTHR0 + 4 * rng), rthr[rng]);
    for (int s = 0; s < 20; s++) begin
      seed = xs(seed);
      sample(seed[0] ? 16'hffd9 : 16'h0027);
    end
    rdc(`TMOF_A_ENGAGED, 32'h0);
    for (int s = 0; s < 3; s++) sample(16'h0064);
    rdc(`TMOF_A_ENGAGED, 32'h2);
    clr(`TMOF_A_CTRL, 32'h1, 4'hf);
    summarize();
  end
endmodule : tb_thermal_model_overcurrent_fuse

// ===== tmof_consts.svh
// Constants for the thermal-model overcurrent fuse block.
// Assumes a single 50 MHz clock and an AHB-Lite register bus.
// Operation
// - Four channels: two user, range, max
// - Accumulator adds i squared plus decay term
// - Accumulator above threshold engages the fuse
// - Break circuit through shunt switch drivers
// - Host clears all or single channel
// - Protection channels always active
// - Range channel uses per-range coefficients
// - Six shunt ranges, six coefficient sets
`ifndef TMOF_CONSTS_SVH
`define TMOF_CONSTS_SVH
`define TMOF_NCH        4
`define TMOF_NRANGE     6
`define TMOF_CH_MAX     2'd3
`define TMOF_CH_RANGE   2'd2
// Register byte offsets
`define TMOF_A_CTRL     8'h00
`define TMOF_A_STAT     8'h04
`define TMOF_A_MASK     8'h08
`define TMOF_A_CLEAR    8'h0c
`define TMOF_A_U0_THR   8'h10
`define TMOF_A_U0_K     8'h14
`define TMOF_A_U1_THR   8'h18
`define TMOF_A_U1_K     8'h1c
`define TMOF_A_MAX_THR  8'h20
`define TMOF_A_MAX_K    8'h24
`define TMOF_A_RTHR0    8'h40
`define TMOF_A_RK0      8'h60
`define TMOF_A_ENGAGED  8'h80
// Field positions
`define TMOF_CTRL_CLRALL 0
`define TMOF_HTRANS_NONSEQ 2'h2
// Shift applied to decay product (K is Q15.16 signed, 16 fraction bits, per step)
`define TMOF_KSHIFT     16
// Reset values: thresholds at full scale, no decay
`define TMOF_THR_RST    32'hffff_ffff
`define TMOF_K_RST      32'h0000_0000
`endif

// ===== tmof_front.sv
// Far-side model: current sample source and range logic shunt requests.
// Assumes the bench raises go_i for one cycle per sample.
`timescale 1ns/1ps
module tmof_front (
  input  wire logic        clk_i,    // Sample clock
  input  wire logic        go_i,     // Sample request
  input  wire logic [15:0] cur_i,    // Current to send
  input  wire logic [2:0]  range_i,  // Range in use
  output logic             valid_o,  // Sample strobe
  output logic      [15:0] cur_o,    // Sample value
  output logic      [5:0]  req_o     // Shunt request
);
  assign req_o = 6'h01 << range_i;
  // Off-strobe data is inverted so a stale value never looks valid
  always_ff @(posedge clk_i) begin
    valid_o <= go_i;
    cur_o   <= go_i ? cur_i : ~cur_o;
  end
endmodule : tmof_front

// ===== tmof_fuse.sv
// Four-channel heating-model fuse with AHB-Lite registers.
// Assumes one clock; samples come from logic on this clock.
// Assumes the range logic settles its own shunt request; this block
// only gates that request off while any fuse is engaged.
`timescale 1ns/1ps
`include "tmof_consts.svh"
module tmof_fuse #(
  parameter int IW = 16,             // Current sample width
  parameter int NSH = 6              // Shunt switch count
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             hsel_i,
  input  wire logic [31:0]      haddr_i,
  input  wire logic [1:0]       htrans_i,
  input  wire logic             hwrite_i,
  input  wire logic [2:0]       hsize_i,
  input  wire logic [31:0]      hwdata_i,
  input  wire logic             hready_i,
  output logic      [31:0]      hrdata_o,
  output logic                  hreadyout_o,
  output logic                  hresp_o,
  input  wire logic             smp_valid_i,  // One-cycle sample strobe
  input  wire logic [IW-1:0]    smp_cur_i,    // Signed current sample
  input  wire logic [2:0]       range_i,      // Selected range 0..5
  input  wire logic [NSH-1:0]   shunt_req_i,  // Range logic switch request
  output logic      [NSH-1:0]   shunt_en_o,   // Shunt switch drive
  output logic                  fuse_open_o,  // Path held open
  output logic                  irq_o
);
  // Coefficients: user0, user1, max; the six range sets stand apart
  tmof_pkg::tmof_coef_type coef_q [3];  // User0, user1, max pairs
  logic [31:0] rthr_q [`TMOF_NRANGE];   // Range thresholds
  logic [31:0] rk_q   [`TMOF_NRANGE];   // Range decay coefficients
  // four independent channels
  // Channel order in every vector: user0, user1, range, max
  // Accumulators are unsigned; the clamp in step keeps them in range
  logic [31:0] acc_q  [`TMOF_NCH];      // Heating accumulators
  logic [`TMOF_NCH-1:0] eng_q;          // Engaged flags
  logic [`TMOF_NCH-1:0] stat_q;         // Sticky trip events
  logic [`TMOF_NCH-1:0] mask_q;         // Interrupt enables
  logic [`TMOF_NCH-1:0] clr_w;          // Per-channel clear
  logic [`TMOF_NCH-1:0] trip_w;         // Accumulator above threshold
  tmof_pkg::tmof_aph_type aph_q;        // Latched address phase
  logic [31:0] rdata_w;                 // Read mux output

  // Saturating accumulator step; negative results floor at zero.
  // The square needs 2*IW bits and the decay product 66, so the sum
  // is formed in 67 signed bits before the clamp.
  function automatic logic [31:0] step(input logic [31:0] a, input logic [31:0] k,
                                       input logic [IW-1:0] i);
    logic signed [2*IW:0] si;
    logic signed [2*IW:0] sq;
    logic signed [65:0] dec;
    logic signed [66:0] sum;
    si  = (2*IW+1)'($signed(i));
    sq  = si * si;
    dec = ($signed({2'b00, a}) * $signed({{34{k[31]}}, k})) >>> `TMOF_KSHIFT;
    // A cooling fuse has a negative decay term, so it is sign extended
    sum = $signed({dec[65], dec}) + $signed({3'b000, a}) + 67'(sq);
    if (sum < 0) step = 32'h0000_0000;
    else if (sum > 67'sh0_ffff_ffff) step = 32'hffff_ffff;
    else step = sum[31:0];
  endfunction : step

  // Per-channel effective coefficients; range channel follows range_i
  // Ranges 6 and 7 do not exist and fall back to set 0
  logic [31:0] thr_w [`TMOF_NCH];
  logic [31:0] k_w   [`TMOF_NCH];
  logic [2:0]  rsel_w;
  assign rsel_w = (range_i < 3'(`TMOF_NRANGE)) ? range_i : 3'h0;
  assign thr_w[0] = coef_q[0].thr;
  assign k_w[0]   = coef_q[0].k;
  assign thr_w[1] = coef_q[1].thr;
  assign k_w[1]   = coef_q[1].k;
  assign thr_w[2] = rthr_q[rsel_w];
  assign k_w[2]   = rk_q[rsel_w];
  assign thr_w[3] = coef_q[2].thr;
  assign k_w[3]   = coef_q[2].k;

  // AHB decode
  // Writes act in the data phase, with the address latched a cycle earlier
  logic       wr_w;
  logic       rd_w;
  assign wr_w = aph_q.wr;
  assign rd_w = hsel_i && hready_i && (htrans_i == `TMOF_HTRANS_NONSEQ) && !hwrite_i;
  logic [7:0] wa_w;
  assign wa_w = aph_q.addr;
  // clear chosen channels by writing the clear register, or all through the control register bit
  assign clr_w = (wr_w && wa_w == `TMOF_A_CLEAR) ? hwdata_i[`TMOF_NCH-1:0] :
                 (wr_w && wa_w == `TMOF_A_CTRL && hwdata_i[`TMOF_CTRL_CLRALL]) ? 4'hf : 4'h0;

  // Address phase capture; writes zero wait, reads take one wait state
  // Address is caught every cycle; only the wr/rd qualifiers gate its use
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aph_q <= '0;
    end else begin
      aph_q.wr   <= hsel_i && hready_i && (htrans_i == `TMOF_HTRANS_NONSEQ) && hwrite_i;
      aph_q.rd   <= rd_w;
      aph_q.addr <= haddr_i[7:0];
    end
  end

  // Coefficient register writes
  // Thresholds reset to full scale so nothing trips before set up
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int c = 0; c < 3; c++) coef_q[c] <= '{thr: `TMOF_THR_RST, k: `TMOF_K_RST};
      for (int r = 0; r < `TMOF_NRANGE; r++) begin
        rthr_q[r] <= `TMOF_THR_RST;
        rk_q[r]   <= `TMOF_K_RST;
      end
      mask_q <= '0;
    end else if (wr_w) begin
      case (wa_w)
        `TMOF_A_U0_THR:  coef_q[0].thr <= hwdata_i;
        `TMOF_A_U0_K:    coef_q[0].k   <= hwdata_i;
        `TMOF_A_U1_THR:  coef_q[1].thr <= hwdata_i;
        `TMOF_A_U1_K:    coef_q[1].k   <= hwdata_i;
        `TMOF_A_MAX_THR: coef_q[2].thr <= hwdata_i;
        `TMOF_A_MAX_K:   coef_q[2].k   <= hwdata_i;
        `TMOF_A_MASK:    mask_q        <= hwdata_i[`TMOF_NCH-1:0];
        default: begin
          for (int r = 0; r < `TMOF_NRANGE; r++) begin
            if (wa_w == `TMOF_A_RTHR0 + 8'(4*r)) rthr_q[r] <= hwdata_i;
            if (wa_w == `TMOF_A_RK0 + 8'(4*r))   rk_q[r]   <= hwdata_i;
          end
        end
      endcase
    end
  end

  // strict compare against threshold
  // A full-scale threshold can never trip, which keeps spare channels quiet
  for (genvar c = 0; c < `TMOF_NCH; c++) begin : g_trip
    assign trip_w[c] = (acc_q[c] > thr_w[c]);
  end

  // Accumulators and engaged flags, all four always running
  // Clear wins over a trip in the same cycle so the host can always reopen
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int c = 0; c < `TMOF_NCH; c++) acc_q[c] <= '0;
      eng_q <= '0;
    end else begin
      for (int c = 0; c < `TMOF_NCH; c++) begin
        if (clr_w[c]) begin
          acc_q[c] <= '0;
          eng_q[c] <= 1'b0;
        end else begin
          if (smp_valid_i) acc_q[c] <= step(acc_q[c], k_w[c], smp_cur_i);
          if (trip_w[c]) eng_q[c] <= 1'b1;
        end
      end
    end
  end

  // Sticky status, set wins over write-one-clear
  // Only the engage edge sets a bit, so a held fuse does not re-raise it
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~((wr_w && wa_w == `TMOF_A_STAT) ? hwdata_i[`TMOF_NCH-1:0] : 4'h0))
                | (trip_w & ~eng_q & ~clr_w);
    end
  end

  // any channel opens regardless of user setup
  // One cycle of lag after engage; the switches cost no extra sensing
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shunt_en_o  <= '0;
      fuse_open_o <= 1'b0;
      irq_o       <= 1'b0;
    end else begin
      fuse_open_o <= |eng_q;
      shunt_en_o  <= (|eng_q) ? '0 : shunt_req_i;
      irq_o       <= |(stat_q & mask_q);
    end
  end

  // Read mux
  assign rdata_w =
    (wa_w == `TMOF_A_STAT)    ? {28'h0, stat_q} :
    (wa_w == `TMOF_A_MASK)    ? {28'h0, mask_q} :
    (wa_w == `TMOF_A_ENGAGED) ? {28'h0, eng_q}  :
    (wa_w == `TMOF_A_U0_THR)  ? coef_q[0].thr :
    (wa_w == `TMOF_A_U0_K)    ? coef_q[0].k :
    (wa_w == `TMOF_A_U1_THR)  ? coef_q[1].thr :
    (wa_w == `TMOF_A_U1_K)    ? coef_q[1].k :
    (wa_w == `TMOF_A_MAX_THR) ? coef_q[2].thr :
    (wa_w == `TMOF_A_MAX_K)   ? coef_q[2].k : 32'h0000_0000;

  // Read data registered so output is a flop; read valid one cycle later
  // The wait state is the price of keeping hrdata_o straight from a flop
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hrdata_o    <= '0;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= !rd_w;   // One wait state on reads
      hresp_o     <= 1'b0;
      if (aph_q.rd) hrdata_o <= rdata_w;
    end
  end

  // Properties run on clk_i and sleep while reset is low.
  // Several also watch inputs: hwdata_i, smp_valid_i, shunt_req_i, range_i.
  // engage follows trip next cycle
  property p_engage;
    @(posedge clk_i) disable iff (!rst_b_i) (trip_w[0] && !clr_w[0]) |=> eng_q[0];
  endproperty
  a_engage: assert property (p_engage) else $error("channel 0 did not engage");
  property p_hold;
    @(posedge clk_i) disable iff (!rst_b_i) (eng_q[3] && !clr_w[3]) |=> eng_q[3];
  endproperty
  a_hold: assert property (p_hold) else $error("engaged dropped without clear");
  sequence s_held0; eng_q[0] && !clr_w[0]; endsequence
  property p_hold0;
    @(posedge clk_i) disable iff (!rst_b_i) s_held0 |=> eng_q[0];
  endproperty
  a_hold0: assert property (p_hold0) else $error("channel 0 dropped without clear");
  property p_clr;
    @(posedge clk_i) disable iff (!rst_b_i) clr_w[1] |=> (!eng_q[1] && acc_q[1] == 32'h0);
  endproperty
  a_clr: assert property (p_clr) else $error("clear did not reset channel");
  property p_clrall;
    @(posedge clk_i) disable iff (!rst_b_i)
      (wr_w && wa_w == `TMOF_A_CTRL && hwdata_i[`TMOF_CTRL_CLRALL]) |=> (eng_q == 4'h0);
  endproperty
  a_clrall: assert property (p_clrall) else $error("clear all left a channel engaged");
  // any engaged channel opens the path
  sequence s_eng; |eng_q; endsequence
  sequence s_open2; ##1 fuse_open_o && shunt_en_o == '0; endsequence
  property p_open;
    @(posedge clk_i) disable iff (!rst_b_i) s_eng |-> s_open2;
  endproperty
  a_open: assert property (p_open) else $error("path not opened");
  // trip, then engage, then the shunts drop
  sequence s_trip0; trip_w[0] && !clr_w[0]; endsequence
  sequence s_walk; eng_q[0] ##1 (fuse_open_o && shunt_en_o == '0); endsequence
  property p_walk;
    @(posedge clk_i) disable iff (!rst_b_i) s_trip0 |=> s_walk;
  endproperty
  a_walk: assert property (p_walk) else $error("trip did not open the path in time");
  // shunts follow the range request while idle
  property p_noeng;
    @(posedge clk_i) disable iff (!rst_b_i) (eng_q == 4'h0) |=> shunt_en_o == $past(shunt_req_i);
  endproperty
  a_noeng: assert property (p_noeng) else $error("shunts not following request");
  // range accumulator moves only on a sample or a clear
  property p_acc;
    @(posedge clk_i) disable iff (!rst_b_i) (!smp_valid_i && clr_w == 4'h0) |=> $stable(acc_q[2]);
  endproperty
  a_acc: assert property (p_acc) else $error("accumulator moved without sample");
  // a channel with no decay never cools
  property p_heat;
    @(posedge clk_i) disable iff (!rst_b_i)
      (smp_valid_i && !clr_w[3] && k_w[3] == 32'h0000_0000) |=> acc_q[3] >= $past(acc_q[3]);
  endproperty
  a_heat: assert property (p_heat) else $error("max accumulator fell without decay");
  // user channel one engages on its own
  sequence s_trip1; trip_w[1] && !clr_w[1]; endsequence
  property p_user1;
    @(posedge clk_i) disable iff (!rst_b_i) s_trip1 |=> eng_q[1];
  endproperty
  a_user1: assert property (p_user1) else $error("channel 1 did not engage");
  // range channel engages on its own
  sequence s_trip2; trip_w[2] && !clr_w[2]; endsequence
  property p_rchan;
    @(posedge clk_i) disable iff (!rst_b_i) s_trip2 |=> eng_q[2];
  endproperty
  a_rchan: assert property (p_rchan) else $error("channel 2 did not engage");
  // max channel engages whatever the user setup
  property p_prot;
    @(posedge clk_i) disable iff (!rst_b_i) (trip_w[3] && !clr_w[3]) |=> eng_q[3];
  endproperty
  a_prot: assert property (p_prot) else $error("max channel failed to engage");
  // range channel trips against the selected range set
  property p_rng;
    @(posedge clk_i) disable iff (!rst_b_i)
      (range_i < 3'(`TMOF_NRANGE) && acc_q[2] > rthr_q[range_i] && !clr_w[2]) |=> eng_q[2];
  endproperty
  a_rng: assert property (p_rng) else $error("range threshold not applied");
  // engage edge sets the sticky status
  property p_stat;
    @(posedge clk_i) disable iff (!rst_b_i) (trip_w[2] && !eng_q[2] && !clr_w[2]) |=> stat_q[2];
  endproperty
  a_stat: assert property (p_stat) else $error("status not set on engage");
  // unmasked trip status raises the interrupt
  property p_irq;
    @(posedge clk_i) disable iff (!rst_b_i) |(stat_q & mask_q) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule : tmof_fuse

// ===== tmof_pkg.sv
// Types for the thermal-model overcurrent fuse block.
// Assumes tmof_consts.svh supplies the numeric constants.
package tmof_pkg;
  // One channel's coefficient pair
  typedef struct packed {
    logic [31:0] thr;   // Trip threshold
    logic [31:0] k;     // Signed decay coefficient times step
  } tmof_coef_type;
  // Latched AHB address phase
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
  } tmof_aph_type;
endpackage : tmof_pkg
